// ==== dv/iapn_cpu_model.sv ====
// Purpose: CPU sequencer and stack model facing the acknowledge block
// Assumes: One-clock instructions; the core stalls while servicing is high
// Notes:   slow lets the stack take a word only every other cycle
module iapn_cpu_model (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Bench controls
  input  wire logic                    slow, // Stack stalls on alternate cycles
  input  wire logic [2:0]              cmd,  // 1 break, 2/3 returns, 4/5 accept on/off
  // Block link
  input  wire iapn_pkg::iapn_cpu_out_s cpu_o,
  output iapn_pkg::iapn_cpu_in_s       cpu_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import iapn_pkg::*;
  logic [7:0]  stk [8]; // Saved status words
  logic [2:0]  sp;      // Stack depth
  logic        tgl;     // Stall phase
  logic [19:0] pc;      // Running address
  // Instructions end every cycle unless the sequence stalls the core
  always_comb begin
    cpu_i = '0;
    cpu_i.instr_done = !cpu_o.servicing;
    cpu_i.break_instruction = (cmd == 3'h1) && !cpu_o.servicing;
    cpu_i.return_maskable_instr = (cmd == 3'h2) && !cpu_o.servicing;
    cpu_i.return_break_instr = (cmd == 3'h3) && !cpu_o.servicing;
    cpu_i.set_accept_instr = (cmd == 3'h4) && !cpu_o.servicing;
    cpu_i.clear_accept_instr = (cmd == 3'h5) && !cpu_o.servicing;
    cpu_i.popped_psw = stk[sp-3'h1];
    cpu_i.resume_pc = pc;
    cpu_i.push_ready = !slow || tgl;
  end
  // Stack keeps status words, pops on returns
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp <= '0;
      tgl <= 1'b0;
      pc <= 20'h00100;
    end else begin
      tgl <= !tgl;
      pc <= pc + 20'h1;
      if (cpu_o.push_valid && cpu_i.push_ready && cpu_o.push_is_psw) begin
        stk[sp] <= cpu_o.push_data[7:0];
        sp <= sp + 3'h1;
      end else if (cpu_i.return_maskable_instr || cpu_i.return_break_instr) begin
        sp <= sp - 3'h1;
      end
    end
  end
endmodule

// ==== dv/interrupt_ack_priority_nesting_tb_top.sv ====
// Purpose: Register and CPU link tests of the acknowledge block
// Assumes: CPU model runs one-clock instructions
// Notes:   Latency counts edges from the edge that samples the event
module interrupt_ack_priority_nesting_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iapn_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] req_event = '0;
  logic slow = 0;
  logic [2:0] cmd = '0;
  iapn_cpu_in_s cpu_i;
  iapn_cpu_out_s cpu_o;
  int cyc = 0, t_ev, t_load, lat, num_errors = 0, checks_done = 0;
  logic [19:0] vec_q[$]; // Vector loads seen
  logic push_q[$];       // Stack word kinds seen
  always #5 aclk = ~aclk;
  iapn_ctrl iapn_ctrl_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .req_event, .cpu_i, .cpu_o);
  iapn_cpu_model iapn_cpu_model_inst (.aclk, .aresetn, .slow, .cmd, .cpu_o, .cpu_i);
  // Monitor of vector loads and stack word order
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cpu_o.pc_load === 1'b1) begin
      vec_q.push_back(cpu_o.pc_load_addr);
      t_load = cyc;
    end
    if (cpu_o.push_valid === 1'b1 && cpu_i.push_ready === 1'b1)
      push_q.push_back(cpu_o.push_is_psw);
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Wait limit ran out
  task automatic tmo();
    chk(32'h1, 32'h0);
    finish_test();
  endtask
  function automatic logic [19:0] vec(input int s);
    return VEC_BASE + 20'(VEC_STRIDE * s);
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 0;
    if (n == 40) tmo();
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 0;
    if (n == 40) tmo();
    chk(s_axi_rdata, ex);
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic cpu_cmd(input logic [2:0] c);
    cmd <= c;
    @(posedge aclk);
    t_ev = cyc;
    cmd <= 3'h0;
    @(posedge aclk);
  endtask
  task automatic ev(input logic [15:0] m);
    req_event <= m;
    @(posedge aclk);
    t_ev = cyc;
    req_event <= '0;
  endtask
  // Waits for a vector load, then checks it and the push order
  task automatic wait_vec(input logic [19:0] e);
    int n;
    for (n = 0; n < 300 && vec_q.size() == 0; n++) @(posedge aclk);
    if (n == 300) tmo();
    lat = t_load - t_ev;
    chk({12'h0, vec_q.pop_front()}, {12'h0, e});
    chk({31'h0, push_q.pop_front()}, 32'h1);
    chk({31'h0, push_q.pop_front()}, 32'h0);
  endtask
  task automatic no_take(input int n);
    repeat (n) @(posedge aclk);
    chk(32'(vec_q.size()), 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    axi_rd(OFS_PSW, 32'h06, RESP_OKAY);
    chk({24'h0, cpu_o.cpu_status_word}, 32'h06);
    axi_rd(OFS_BLOCK, 32'hffff, RESP_OKAY);
    axi_rd(OFS_LVL_HI, 32'hffff, RESP_OKAY);
    axi_rd(8'h1c, 32'h0, RESP_SLVERR);
    axi_wr(8'h1c, 32'h1, RESP_SLVERR);
    $display("test reset done");
    ev(16'h0008);
    no_take(20);
    axi_rd(OFS_REQ, 32'h8, RESP_OKAY);
    axi_wr(OFS_BLOCK, 32'hfff7, RESP_OKAY);
    no_take(20);
    cpu_cmd(3'h4);
    wait_vec(vec(3));
    axi_rd(OFS_REQ, 32'h0, RESP_OKAY);
    axi_rd(OFS_PSW, 32'h04, RESP_OKAY);
    chk({24'h0, cpu_o.cpu_status_word}, 32'h04);
    cpu_cmd(3'h2);
    axi_rd(OFS_PSW, 32'h86, RESP_OKAY);
    ev(16'h0008);
    wait_vec(vec(3));
    chk(32'(lat >= 10 && lat <= 17), 32'h1);
    cpu_cmd(3'h2);
    $display("test pending and latency done");
    axi_wr(OFS_LVL_LO, 32'hfd7f, RESP_OKAY);
    axi_wr(OFS_LVL_HI, 32'hfd5b, RESP_OKAY);
    axi_wr(OFS_BLOCK, 32'h0, RESP_OKAY);
    ev(16'h00a4);
    wait_vec(vec(7));
    axi_rd(OFS_PSW, 32'h00, RESP_OKAY);
    cpu_cmd(3'h4);
    no_take(20);
    ev(16'h0200);
    wait_vec(vec(9));
    cpu_cmd(3'h2);
    cpu_cmd(3'h2);
    wait_vec(vec(2));
    chk(32'(lat >= 5), 32'h1);
    cpu_cmd(3'h2);
    wait_vec(vec(5));
    cpu_cmd(3'h2);
    $display("test nesting done");
    cpu_cmd(3'h5);
    slow <= 1;
    cpu_cmd(3'h1);
    wait_vec(BRK_VEC_ADDR);
    axi_rd(OFS_PSW, 32'h06, RESP_OKAY);
    cpu_cmd(3'h4);
    ev(16'h0008);
    wait_vec(vec(3));
    cpu_cmd(3'h2);
    cpu_cmd(3'h3);
    axi_rd(OFS_PSW, 32'h06, RESP_OKAY);
    slow <= 0;
    $display("test break done");
    finish_test();
  end
endmodule

// ==== rtl/iapn_ctrl.sv ====
// Purpose: Maskable request acknowledgment, priority nesting and break handling
// Assumes: Edge detection of request sources is done outside; CPU stalls during the sequence
// Notes:   Registers on AXI4-Lite; one acknowledge sequence at a time
//
// Operation
// - Eligible only with flag set, block clear
// - Take only with accept enable, priority allowing
// - Vector load 9 to 16 clocks after request
// - Upper bound waived running from internal RAM
// - Best level first, then default order
// - Refused requests stay pending, taken when allowed
// - Push status, push PC, clear enable, vector
// - Maskable return restores PC and status word
// - Break instruction always taken, never masked
// - Break pushes, clears enable, vectors to 7E
// - Break handler leaves with break return only
// - Nest only strictly higher priority requests
// - Level 0 service still nests level 0
// - Refused by enable or priority stays pending
// - One interrupted instruction runs before pending taken
// - In-service field encodes levels, 11 idle
// - Two-bit setting 00 highest, 11 lowest
// - During break service any enabled level nests
// - In-service loaded with setting minus one
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
module iapn_ctrl #(
  parameter int unsigned N_SRC     = 16, // Number of maskable sources
  parameter int unsigned NEST_MAX  = 8   // Depth of nesting record
) (
  // Clock and reset
  input  wire  logic                   aclk,
  input  wire  logic                   aresetn,
  // AXI4-Lite write address and data
  input  wire  logic                   s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire  logic [7:0]             s_axi_awaddr,
  input  wire  logic                   s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire  logic [31:0]            s_axi_wdata,
  input  wire  logic [3:0]             s_axi_wstrb,
  // AXI4-Lite write response
  output logic                         s_axi_bvalid,
  input  wire  logic                   s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // AXI4-Lite read
  input  wire  logic                   s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire  logic [7:0]             s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire  logic                   s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // Request events from sources
  input  wire  logic [N_SRC-1:0]       req_event,
  // CPU sequencer and stack
  input  wire  iapn_pkg::iapn_cpu_in_s cpu_i,
  output iapn_pkg::iapn_cpu_out_s      cpu_o
);
  import iapn_pkg::*;

  localparam int unsigned IW = (N_SRC > 1) ? $clog2(N_SRC) : 1; // Source index width
  localparam int unsigned DW = $clog2(NEST_MAX + 1);             // Nesting count width

  // Whole module state
  typedef struct packed {
    logic [N_SRC-1:0]       req;        // Pending flags
    logic [N_SRC-1:0]       block;      // Block flags
    logic [N_SRC-1:0]       lvl_lo;     // Level select low bits
    logic [N_SRC-1:0]       lvl_hi;     // Level select high bits
    logic [N_SRC-1:0][3:0]  age;        // Clocks since each flag rose
    logic                   ie;         // Global accept enable
    logic [1:0]             isp;        // In-service level field
    logic                   hold;       // One instruction must run first
    logic [NEST_MAX-1:0]    kind;       // Nesting record, 1 = break
    logic [DW-1:0]          depth;      // Handlers entered
    iapn_phase_e            phase;      // Sequencer phase
    logic                   cur_brk;    // Current sequence is a break
    logic [IW-1:0]          cur_src;    // Source being acknowledged
    logic [19:0]            push_word;  // Word offered to the stack
    logic [19:0]            resume_pc;  // PC held for the second push
    logic [19:0]            vec_addr;   // Vector entry address
    logic                   aw_got;     // Write address latched
    logic                   w_got;      // Write data latched
    logic [7:0]             awaddr;     // Latched write address
    logic [31:0]            wdata;      // Latched write data
    logic                   bvalid;     // Write response pending
    logic [1:0]             bresp;      // Write response code
    logic                   rvalid;     // Read data pending
    logic [31:0]            rdata;      // Read data
    logic [1:0]             rresp;      // Read response code
  } iapn_state_s;

  iapn_state_s s;      // Registered state
  iapn_state_s next_s; // Next state

  // Level of a source from its two select bits
  function automatic logic [1:0] lvl_of(input iapn_state_s st, input int unsigned i);
    lvl_of = {st.lvl_hi[i], st.lvl_lo[i]};
  endfunction

  // Level allowed against the in-service field: 00 admits only level 0
  function automatic logic lvl_ok(input logic [1:0] lvl, input logic [1:0] isp);
    lvl_ok = (lvl <= isp);
  endfunction

  // In-service field loaded on acknowledge
  function automatic logic [1:0] isp_from(input logic [1:0] lvl);
    isp_from = (lvl == LVL_TOP) ? LVL_TOP : lvl - 2'h1;
  endfunction

  // Status word assembled from held and CPU bits
  function automatic logic [7:0] psw_pack(input logic ie, input logic [1:0] isp,
                                          input logic [7:0] oth);
    psw_pack           = oth;
    psw_pack[PSW_IE]   = ie;
    psw_pack[PSW_IN_SERVICE_LEVEL_HIGH] = isp[1];
    psw_pack[PSW_IN_SERVICE_LEVEL_LOW] = isp[0];
  endfunction

  // Arbitration results
  logic [N_SRC-1:0] elig;     // Eligible and old enough
  logic             win_any;  // Some source eligible
  logic [IW-1:0]    win;      // Winning source
  logic [1:0]       win_lvl;  // Winner level
  logic             top_brk;  // Innermost handler is a break
  logic             take_m;   // Maskable acknowledge this cycle
  logic             take_b;   // Break acknowledge this cycle
  logic             wr_fire;  // Bus write performed
  logic             rd_fire;  // Bus read accepted

  // Eligibility and priority pick; scanning downward lets lower index win ties
  always_comb begin
    win_any = 1'b0;
    win     = '0;
    win_lvl = ISP_IDLE;
    for (int unsigned i = 0; i < N_SRC; i++) begin
      elig[i] = s.req[i] && !s.block[i] && (s.age[i] >= TAKE_AGE);
    end
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (elig[i] && (!win_any || lvl_of(s, i) <= win_lvl)) begin
        win_any = 1'b1;
        win     = IW'(i);
        win_lvl = lvl_of(s, i);
      end
    end
  end

  // Acknowledge decision at an instruction boundary
  always_comb begin
    top_brk = (s.depth != '0) && s.kind[0];
    take_b  = (s.phase == PH_IDLE) && cpu_i.break_instruction;
    // Refused requests simply stay in req until this holds
    // Upper latency bound rests on the CPU boundary rate, waived from internal RAM
    // A return's own boundary never takes, or its pop and restore would be lost
    take_m  = (s.phase == PH_IDLE) && !take_b && cpu_i.instr_done &&
              !cpu_i.return_maskable_instr && !cpu_i.return_break_instr &&
              !cpu_i.holds_pending && !s.hold && win_any && s.ie &&
              (top_brk || lvl_ok(win_lvl, s.isp));
    wr_fire = s.aw_got && s.w_got && !s.bvalid;
    rd_fire = s_axi_arvalid && !s.rvalid;
  end

  // Next-state logic
  always_comb begin
    next_s = s;
    // Request ages: restart while clear, saturate while pending
    for (int unsigned i = 0; i < N_SRC; i++) begin
      if (!s.req[i]) begin
        next_s.age[i] = '0;
      end else if (s.age[i] != AGE_SAT) begin
        next_s.age[i] = s.age[i] + 4'h1;
      end
    end
    // Bus write channel: address and data in either order
    if (s_axi_awvalid && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // Register writes; whole-word only, partial strobes still write low lanes
    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      unique case ({s.awaddr[7:2], 2'b00})
        OFS_REQ:     next_s.req    = s.req & ~s.wdata[N_SRC-1:0];
        OFS_REQ_SET: next_s.req    = s.req | s.wdata[N_SRC-1:0];
        OFS_BLOCK:   next_s.block  = s.wdata[N_SRC-1:0];
        OFS_LVL_LO:  next_s.lvl_lo = s.wdata[N_SRC-1:0];
        OFS_LVL_HI:  next_s.lvl_hi = s.wdata[N_SRC-1:0];
        OFS_PSW: begin
          next_s.ie  = s.wdata[PSW_IE];
          next_s.isp = {s.wdata[PSW_IN_SERVICE_LEVEL_HIGH], s.wdata[PSW_IN_SERVICE_LEVEL_LOW]};
        end
        OFS_STATUS:  next_s.bresp  = RESP_OKAY; // Read-only, write ignored
        default:     next_s.bresp  = RESP_SLVERR; // Unmapped
      endcase
    end
    // Bus read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = '0;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFS_REQ:     next_s.rdata[N_SRC-1:0] = s.req;
        OFS_REQ_SET: next_s.rdata[N_SRC-1:0] = s.req;
        OFS_BLOCK:   next_s.rdata[N_SRC-1:0] = s.block;
        OFS_LVL_LO:  next_s.rdata[N_SRC-1:0] = s.lvl_lo;
        OFS_LVL_HI:  next_s.rdata[N_SRC-1:0] = s.lvl_hi;
        OFS_PSW:     next_s.rdata[7:0]       = psw_pack(s.ie, s.isp, '0);
        OFS_STATUS:  next_s.rdata = 32'({s.hold, s.depth, s.cur_src, s.phase});
        default:     next_s.rresp = RESP_SLVERR; // Unmapped reads as zero
      endcase
    end
    // Enable and disable instructions
    if (cpu_i.set_accept_instr) begin
      next_s.ie = 1'b1;
    end else if (cpu_i.clear_accept_instr) begin
      next_s.ie = 1'b0;
    end
    // Returns restore status bits and defer the next take by one instruction
    if (cpu_i.return_maskable_instr || cpu_i.return_break_instr) begin
      next_s.ie   = cpu_i.popped_psw[PSW_IE];
      next_s.isp  = {cpu_i.popped_psw[PSW_IN_SERVICE_LEVEL_HIGH], cpu_i.popped_psw[PSW_IN_SERVICE_LEVEL_LOW]};
      next_s.hold = 1'b1;
      if (s.depth != '0) begin
        next_s.kind  = s.kind >> 1;
        next_s.depth = s.depth - DW'(1);
      end
    end else if (cpu_i.instr_done) begin
      next_s.hold = 1'b0;
    end
    // Sequencer
    unique case (s.phase)
      PH_IDLE: begin
        if (take_b || take_m) begin
          next_s.phase     = PH_PUSH_PSW;
          next_s.cur_brk   = take_b;
          next_s.push_word = 20'(psw_pack(s.ie, s.isp, cpu_i.psw_other));
          next_s.resume_pc = cpu_i.resume_pc;
          next_s.ie        = 1'b0;
          next_s.kind      = {s.kind[NEST_MAX-2:0], take_b};
          if (s.depth != DW'(NEST_MAX)) begin
            next_s.depth = s.depth + DW'(1);
          end
          if (take_b) begin
            next_s.vec_addr = BRK_VEC_ADDR;
          end else begin
            next_s.cur_src  = win;
            next_s.isp      = isp_from(win_lvl);
            next_s.vec_addr = VEC_BASE + 20'(VEC_STRIDE * win);
          end
        end
      end
      PH_PUSH_PSW: begin
        if (cpu_i.push_ready) begin
          next_s.phase     = PH_PUSH_PC;
          next_s.push_word = s.resume_pc;
        end
      end
      PH_PUSH_PC: begin
        if (cpu_i.push_ready) begin
          next_s.phase = PH_VECTOR;
        end
      end
      PH_VECTOR: begin
        next_s.phase = PH_IDLE;
      end
    endcase
    // Taken flag cleared, new events set and win over any clear
    if (take_m) begin
      next_s.req[win] = 1'b0;
    end
    next_s.req = next_s.req | req_event;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s        <= '0;
      s.block  <= '1;
      s.lvl_lo <= '1;
      s.lvl_hi <= '1;
      s.ie     <= PSW_RESET[PSW_IE];
      s.isp    <= {PSW_RESET[PSW_IN_SERVICE_LEVEL_HIGH], PSW_RESET[PSW_IN_SERVICE_LEVEL_LOW]};
      s.phase  <= PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Port drive
  always_comb begin
    s_axi_awready         = !s.aw_got;
    s_axi_wready          = !s.w_got;
    s_axi_bvalid          = s.bvalid;
    s_axi_bresp           = s.bresp;
    s_axi_arready         = !s.rvalid;
    s_axi_rvalid          = s.rvalid;
    s_axi_rdata           = s.rdata;
    s_axi_rresp           = s.rresp;
    cpu_o.servicing       = (s.phase != PH_IDLE);
    cpu_o.push_valid      = (s.phase == PH_PUSH_PSW) || (s.phase == PH_PUSH_PC);
    cpu_o.push_is_psw     = (s.phase == PH_PUSH_PSW);
    cpu_o.push_data       = s.push_word;
    cpu_o.pc_load         = (s.phase == PH_VECTOR);
    cpu_o.pc_load_addr    = s.vec_addr;
    cpu_o.cpu_status_word = psw_pack(s.ie, s.isp, cpu_i.psw_other);
  end

  // Helper: a strictly better eligible source than the winner exists
  logic better;
  always_comb begin
    better = 1'b0;
    for (int unsigned j = 0; j < N_SRC; j++) begin
      if (elig[j] && ((lvl_of(s, j) < win_lvl) || (lvl_of(s, j) == win_lvl && j < win))) begin
        better = 1'b1;
      end
    end
  end

  property p_eligible;
    @(posedge aclk) disable iff (!aresetn)
      take_m |-> (s.req[win] && !s.block[win]);
  endproperty
  a_eligible: assert property (p_eligible) else $error("taken source not eligible");

  property p_enable;
    @(posedge aclk) disable iff (!aresetn)
      take_m |-> s.ie ##1 (!s.ie && s.phase == PH_PUSH_PSW);
  endproperty
  a_enable: assert property (p_enable) else $error("take without enable or no clear");

  property p_min_lat;
    @(posedge aclk) disable iff (!aresetn)
      take_m |-> (s.age[win] >= 4'(LAT_MIN_CLK - SEQ_CLK)) ##1 cpu_o.push_valid[*1] ##1 1'b1;
  endproperty
  a_min_lat: assert property (p_min_lat) else $error("vector load too early");

  property p_best;
    @(posedge aclk) disable iff (!aresetn)
      take_m |-> !better;
  endproperty
  a_best: assert property (p_best) else $error("better request was passed over");

  property p_isp_load;
    @(posedge aclk) disable iff (!aresetn)
      take_m |=> (s.isp == isp_from($past(win_lvl)));
  endproperty
  a_isp_load: assert property (p_isp_load) else $error("in-service field wrong");

  property p_break;
    @(posedge aclk) disable iff (!aresetn)
      take_b |=> (s.cur_brk && !s.ie && s.vec_addr == BRK_VEC_ADDR);
  endproperty
  a_break: assert property (p_break) else $error("break not acknowledged");

  property p_nest;
    @(posedge aclk) disable iff (!aresetn)
      (take_m && s.depth != '0 && !top_brk) |-> (win_lvl <= s.isp);
  endproperty
  a_nest: assert property (p_nest) else $error("nested lower priority request");

  property p_pending;
    @(posedge aclk) disable iff (!aresetn)
      (s.req[win] && !take_m && !wr_fire) |=> s.req[$past(win)];
  endproperty
  a_pending: assert property (p_pending) else $error("refused request was lost");

  property p_after_ret;
    @(posedge aclk) disable iff (!aresetn)
      (cpu_i.return_maskable_instr || cpu_i.return_break_instr) |-> !take_m ##1 !take_m;
  endproperty
  a_after_ret: assert property (p_after_ret) else $error("taken right after return");
endmodule

// ==== rtl/iapn_pkg.sv ====
// Purpose: Shared constants and carriers for the interrupt acknowledge and nesting block
// Assumes: 32-bit AXI4-Lite register access, 100 MHz CPU clock
// Notes:   Offsets are byte addresses of aligned 32-bit words
package iapn_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_REQ     = 8'h00; // Pending flags, write 1 clears
  localparam logic [7:0] OFS_BLOCK   = 8'h04; // Per-source block flags
  localparam logic [7:0] OFS_LVL_LO  = 8'h08; // Level select, low bits
  localparam logic [7:0] OFS_LVL_HI  = 8'h0c; // Level select, high bits
  localparam logic [7:0] OFS_PSW     = 8'h10; // Status word accept/in-service bits
  localparam logic [7:0] OFS_STATUS  = 8'h14; // Read-only sequencer state
  localparam logic [7:0] OFS_REQ_SET = 8'h18; // Write 1 raises a request
  // Status word bit positions and reset value
  localparam int unsigned  PSW_IE    = 7;
  localparam int unsigned  PSW_IN_SERVICE_LEVEL_HIGH  = 2;
  localparam int unsigned  PSW_IN_SERVICE_LEVEL_LOW  = 1;
  localparam logic [7:0]   PSW_RESET = 8'h06;
  localparam logic [1:0]   ISP_IDLE  = 2'h3; // Nothing in service
  localparam logic [1:0]   LVL_TOP   = 2'h0; // Highest programmable level
  // Vector addresses
  localparam logic [19:0]  BRK_VEC_ADDR = 20'h0007e; // Table word at 7E/7F
  localparam logic [19:0]  VEC_BASE     = 20'h00004; // First maskable entry
  localparam int unsigned  VEC_STRIDE   = 2;         // Bytes per table entry
  // Latency figures in CPU clocks
  localparam int unsigned  CLK_PERIOD_NS = 10;
  localparam int unsigned  LAT_MIN_CLK   = 9;
  localparam int unsigned  LAT_MAX_CLK   = 16;
  localparam int unsigned  SEQ_CLK       = 3;  // Take to vector load, no stall
  localparam logic [3:0]   TAKE_AGE      = 4'(LAT_MIN_CLK - SEQ_CLK);
  localparam logic [3:0]   AGE_SAT       = 4'hf;
  // Bus responses
  localparam logic [1:0]   RESP_OKAY   = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;
  // Sequencer phases
  typedef enum logic [1:0] {PH_IDLE, PH_PUSH_PSW, PH_PUSH_PC, PH_VECTOR} iapn_phase_e;
  // From the CPU instruction sequencer and stack logic
  typedef struct packed {
    logic        instr_done;            // Instruction boundary pulse
    logic        holds_pending;         // Finishing instruction defers taking
    logic        in_internal_ram;       // Fetching from internal RAM
    logic        break_instruction;     // Break executes (pulse)
    logic        return_maskable_instr; // Maskable return, with its instr_done
    logic        return_break_instr;    // Break return, with its instr_done
    logic        set_accept_instr;      // Enable instruction
    logic        clear_accept_instr;    // Disable instruction
    logic [7:0]  popped_psw;            // Status word popped by a return
    logic [7:0]  psw_other;             // Remaining status word bits
    logic [19:0] resume_pc;             // Address to resume at
    logic        push_ready;            // Stack takes a word
  } iapn_cpu_in_s;
  // To the CPU
  typedef struct packed {
    logic        servicing;       // Acknowledge sequence running
    logic        push_valid;      // Word offered to the stack
    logic        push_is_psw;     // Offered word is the status word
    logic [19:0] push_data;       // Offered word
    logic        pc_load;         // Load PC from table entry (pulse)
    logic [19:0] pc_load_addr;    // Table entry address
    logic [7:0]  cpu_status_word; // Live status word
  } iapn_cpu_out_s;
endpackage
